// ===== rtl/dual_capture_compare_array.sv
// Overview of operation
// - Two independent sixteen-channel units, thirty-two channels, finest step eight clocks.
// - Each unit has two 16-bit timers, each with its own reload register.
// - Timer input is a prescaled system clock or aux timer overflow events.
// - The first timer of each unit may count edges on an external pin.
// - Each channel picks either unit timer and capture or compare operation.
// - Each channel owns one pin: capture trigger input or compare output.
// - A capture latches the assigned timer and raises the channel interrupt request.
// - Capture triggers on rising, falling or both pin edges, chosen per channel.
// - Compare channels match their timer on each timer step and act per one of five modes.
// - Mode 0: interrupt only, pin untouched, many matches per period.
// - Mode 1: pin inverts on every match, many per period.
// - Mode 2: interrupt only, at most one per timer period.
// - Mode 3: pin set on match, cleared on timer overflow, once per period.
// - Double mode: two channels share one pin and either match toggles it.
// - Three-bit select picks prescale 8 for 000b, doubling up to 1024.
// - Overflow restarts the timer from reload; reload 0000h gives 65536 counts.
`timescale 1ns/1ps
module dual_capture_compare_array (
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic        CE,
	input  wire logic [11:0] AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic [31:0] CC_PIN_IN,
	output logic      [31:0] CC_PIN_OUT,
	output logic      [31:0] CC_PIN_OE,
	input  wire logic [1:0]  EXT_COUNT_IN,
	input  wire logic        AUX_OVF_IN,
	output logic             IRQ
);
	logic [9:0]  presc_q;
	logic [5:0]  tctrl_q [4];
	logic [4:0]  ccmode_q [32];
	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [31:0] enable_q;
	logic [31:0] clr_vec;
	logic [31:0] pin_q;
	logic [31:0] oe_q;
	logic        irq_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [11:0] a_w;
	logic        acc;
	logic        wr;
	logic [15:0] tval [4];
	logic [15:0] trld [4];
	logic [15:0] ccval [32];
	logic [31:0] ch_irq;
	logic [31:0] ch_set;
	logic [31:0] ch_clr;
	logic [31:0] ch_tgl;
	logic [31:0] ch_dbl;
	logic [31:0] pin_tgl_v;
	logic [31:0] oe_d;

	ccu_tmr_if tif [4] ();

	assign a_w = {AVS_ADDRESS[11:2], 2'b00};
	// A request completes at the edge where it sees waitrequest low; writes act only there.
	assign acc = (AVS_READ || AVS_WRITE) && !wait_q && CE;
	assign wr  = acc && AVS_WRITE;

	assign AVS_READDATA    = rdata_q;
	assign AVS_WAITREQUEST = wait_q;
	assign CC_PIN_OUT      = pin_q;
	assign CC_PIN_OE       = oe_q;
	assign IRQ             = irq_q;

	// One shared free-running prescaler serves every timer, so timers on the same select tick together.
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			presc_q <= 10'h000;
		else if (CE)
			presc_q <= presc_q + 10'h001;
	end

	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_tmr
			assign tif[i].sel    = tctrl_q[i][ccu_pkg::SEL_LSB +: 3];
			assign tif[i].src    = ccu_pkg::tsrc_t'(tctrl_q[i][ccu_pkg::SRC_LSB +: 2]);
			assign tif[i].run    = tctrl_q[i][ccu_pkg::RUN_BIT];
			assign tif[i].wdata  = AVS_WRITEDATA[15:0];
			assign tif[i].wr_val = wr && a_w == ccu_pkg::reg_addr(ccu_pkg::TMR_BASE, ccu_pkg::TMR_STRIDE, i)
				+ ccu_pkg::TVAL_OFS;
			assign tif[i].wr_rld = wr && a_w == ccu_pkg::reg_addr(ccu_pkg::TMR_BASE, ccu_pkg::TMR_STRIDE, i)
				+ ccu_pkg::TRLD_OFS;
			assign tval[i]       = tif[i].value;
			assign trld[i]       = tif[i].reload;

			ccu_timer #(
				.HAS_EXT (i % 2 == 0)
			) u_tmr (
				.clk     (SYS_CLK),
				.srst    (SRST),
				.ce      (CE),
				.presc   (presc_q),
				.aux_ovf (AUX_OVF_IN),
				.ext_in  (EXT_COUNT_IN[i / 2]),
				.t       (tif[i])
			);

			always_ff @(posedge SYS_CLK)
			begin
				if (SRST)
					tctrl_q[i] <= ccu_pkg::TCTRL_RST;
				else if (wr && a_w == ccu_pkg::reg_addr(ccu_pkg::TMR_BASE, ccu_pkg::TMR_STRIDE, i)
					+ ccu_pkg::TCTRL_OFS)
					tctrl_q[i] <= AVS_WRITEDATA[5:0];
			end
		end
	endgenerate

	genvar k;
	generate
		for (k = 0; k < 32; k++)
		begin : g_ch
			localparam int U = k / 16;

			always_ff @(posedge SYS_CLK)
			begin
				if (SRST)
					ccmode_q[k] <= ccu_pkg::CCMODE_RST;
				else if (wr && a_w == ccu_pkg::reg_addr(ccu_pkg::CCMODE_BASE, 12'h004, k))
					ccmode_q[k] <= AVS_WRITEDATA[4:0];
			end

			ccu_channel u_ch (
				.clk     (SYS_CLK),
				.srst    (SRST),
				.ce      (CE),
				.mode    (ccu_pkg::cc_mode_t'(ccmode_q[k][3:0])),
				.tsel    (ccmode_q[k][ccu_pkg::MODE_TSEL_BIT]),
				.tv0     (tif[2 * U].value),
				.tv1     (tif[2 * U + 1].value),
				.step    ({tif[2 * U + 1].step, tif[2 * U].step}),
				.ovf     ({tif[2 * U + 1].ovf, tif[2 * U].ovf}),
				.pin_in  (CC_PIN_IN[k]),
				.wr      (wr && a_w == ccu_pkg::reg_addr(ccu_pkg::CCVAL_BASE, 12'h004, k)),
				.wdata   (AVS_WRITEDATA[15:0]),
				.value   (ccval[k]),
				.irq_set (ch_irq[k]),
				.pin_set (ch_set[k]),
				.pin_clr (ch_clr[k]),
				.pin_tgl (ch_tgl[k]),
				.dbl_tgl (ch_dbl[k])
			);

			// In double mode the upper eight channels of a unit steer the pin of channel k minus eight.
			if ((k % 16) < 8)
			begin : g_lo
				assign pin_tgl_v[k] = ch_tgl[k] || ch_dbl[k] || ch_dbl[k + 8];
				assign oe_d[k]      = ccmode_q[k][3:0] inside {ccu_pkg::CM_CMP1, ccu_pkg::CM_CMP3, ccu_pkg::CM_DOUBLE}
					|| ccmode_q[k + 8][3:0] == ccu_pkg::CM_DOUBLE;
			end
			else
			begin : g_hi
				assign pin_tgl_v[k] = ch_tgl[k];
				assign oe_d[k]      = ccmode_q[k][3:0] inside {ccu_pkg::CM_CMP1, ccu_pkg::CM_CMP3};
			end

			// A set from mode 3 wins over the overflow clear of the same cycle.
			always_ff @(posedge SYS_CLK)
			begin
				if (SRST)
					pin_q[k] <= 1'b0;
				else if (CE)
				begin
					if (ch_set[k])
						pin_q[k] <= 1'b1;
					else if (ch_clr[k])
						pin_q[k] <= 1'b0;
					else if (pin_tgl_v[k])
						pin_q[k] <= !pin_q[k];
				end
			end

			chk_pin_toggle: assert property (@(posedge SYS_CLK) disable iff (SRST)
				CE && pin_tgl_v[k] && !ch_set[k] && !ch_clr[k] |=> pin_q[k] != $past(pin_q[k]))
				else $error("pin did not toggle on match");
		end
	endgenerate

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			oe_q <= 32'h0000_0000;
		else if (CE)
			oe_q <= oe_d;
	end

	assign clr_vec  = (wr && a_w == ccu_pkg::CLEAR_OFS) ? AVS_WRITEDATA : 32'h0000_0000;
	// A hardware event in the clearing cycle wins, so it is never lost.
	assign status_d = (status_q & ~clr_vec) | ch_irq;

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			status_q <= ccu_pkg::STATUS_RST;
		else if (CE)
			status_q <= status_d;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			enable_q <= 32'h0000_0000;
		else if (wr && a_w == ccu_pkg::ENABLE_OFS)
			enable_q <= AVS_WRITEDATA;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			irq_q <= 1'b0;
		else if (CE)
			irq_q <= |(status_d & enable_q);
	end

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (a_w == ccu_pkg::STATUS_OFS)
			rdata_d = status_q;
		if (a_w == ccu_pkg::ENABLE_OFS)
			rdata_d = enable_q;
		if (a_w == ccu_pkg::PIN_OFS)
			rdata_d = CC_PIN_IN;
		for (int n = 0; n < 4; n++)
		begin
			if (a_w == ccu_pkg::reg_addr(ccu_pkg::TMR_BASE, ccu_pkg::TMR_STRIDE, n) + ccu_pkg::TCTRL_OFS)
				rdata_d = {26'h0, tctrl_q[n]};
			if (a_w == ccu_pkg::reg_addr(ccu_pkg::TMR_BASE, ccu_pkg::TMR_STRIDE, n) + ccu_pkg::TVAL_OFS)
				rdata_d = {16'h0000, tval[n]};
			if (a_w == ccu_pkg::reg_addr(ccu_pkg::TMR_BASE, ccu_pkg::TMR_STRIDE, n) + ccu_pkg::TRLD_OFS)
				rdata_d = {16'h0000, trld[n]};
		end
		for (int n = 0; n < 32; n++)
		begin
			if (a_w == ccu_pkg::reg_addr(ccu_pkg::CCVAL_BASE, 12'h004, n))
				rdata_d = {16'h0000, ccval[n]};
			if (a_w == ccu_pkg::reg_addr(ccu_pkg::CCMODE_BASE, 12'h004, n))
				rdata_d = {27'h0, ccmode_q[n]};
		end
	end

	// Every access takes two cycles: waitrequest drops one cycle after the request and rises again after it.
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else if (CE)
		begin
			if ((AVS_READ || AVS_WRITE) && wait_q)
			begin
				wait_q  <= 1'b0;
				rdata_q <= rdata_d;
			end
			else
				wait_q <= 1'b1;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	chk_flag_sticky: assert property ((status_q & $past(status_q) & ~$past(clr_vec))
		== ($past(status_q) & ~$past(clr_vec)))
		else $error("request flag dropped without a clear");
	chk_event_flag: assert property (CE |=> (status_q & $past(ch_irq)) == $past(ch_irq))
		else $error("channel event did not set its flag");
	chk_irq_level: assert property (CE && |(status_q & enable_q) && !(|clr_vec) |=> IRQ)
		else $error("interrupt output low with an enabled flag");
	chk_bus_answer: assert property (CE && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request not answered in one cycle");
endmodule // dual_capture_compare_array

// ===== rtl/ccu_pkg.sv
package ccu_pkg;

	localparam logic [11:0] STATUS_OFS  = 12'h000;
	localparam logic [11:0] CLEAR_OFS   = 12'h004;
	localparam logic [11:0] ENABLE_OFS  = 12'h008;
	localparam logic [11:0] PIN_OFS     = 12'h00c;
	localparam logic [11:0] TMR_BASE    = 12'h040;
	localparam logic [11:0] TMR_STRIDE  = 12'h010;
	localparam logic [11:0] TCTRL_OFS   = 12'h000;
	localparam logic [11:0] TVAL_OFS    = 12'h004;
	localparam logic [11:0] TRLD_OFS    = 12'h008;
	localparam logic [11:0] CCVAL_BASE  = 12'h100;
	localparam logic [11:0] CCMODE_BASE = 12'h200;

	localparam int SEL_LSB       = 0;
	localparam int SRC_LSB       = 3;
	localparam int RUN_BIT       = 5;
	localparam int MODE_TSEL_BIT = 4;

	localparam logic [5:0]  TCTRL_RST  = 6'h00;
	localparam logic [15:0] TVAL_RST   = 16'h0000;
	localparam logic [15:0] TRLD_RST   = 16'h0000;
	localparam logic [4:0]  CCMODE_RST = 5'h00;
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	localparam logic [15:0] TMR_MAX    = 16'hffff;
	localparam logic [10:0] PRESC_MIN  = 11'h008;

	typedef enum logic [1:0] {
		SRC_PRESC = 2'h0,
		SRC_AUX   = 2'h1,
		SRC_EXT   = 2'h2
	} tsrc_t;

	typedef enum logic [3:0] {
		CM_OFF      = 4'h0,
		CM_CAP_RISE = 4'h1,
		CM_CAP_FALL = 4'h2,
		CM_CAP_BOTH = 4'h3,
		CM_CMP0     = 4'h4,
		CM_CMP1     = 4'h5,
		CM_CMP2     = 4'h6,
		CM_CMP3     = 4'h7,
		CM_DOUBLE   = 4'h8
	} cc_mode_t;

	// Prescale factor is 8 for code 0 and doubles per step up to 1024.
	function automatic logic presc_tick(input logic [9:0] cnt, input logic [2:0] sel);
		logic [9:0] m;
		m = 10'((PRESC_MIN << sel) - 11'h001);
		return (cnt & m) == m;
	endfunction

	function automatic logic [11:0] reg_addr(input logic [11:0] base, input logic [11:0] stride, input int idx);
		return 12'(base + stride * 12'(idx));
	endfunction

endpackage

// ===== rtl/ccu_tmr_if.sv
`timescale 1ns/1ps
interface ccu_tmr_if;
	logic [2:0]      sel;
	ccu_pkg::tsrc_t  src;
	logic            run;
	logic            wr_val;
	logic            wr_rld;
	logic [15:0]     wdata;
	logic [15:0]     value;
	logic [15:0]     reload;
	logic            step;
	logic            ovf;
	modport ctl (output sel, src, run, wr_val, wr_rld, wdata, input value, reload, step, ovf);
	modport tmr (input sel, src, run, wr_val, wr_rld, wdata, output value, reload, step, ovf);
endinterface

// ===== rtl/ccu_timer.sv
`timescale 1ns/1ps
module ccu_timer #(
	parameter bit HAS_EXT = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic [9:0] presc,
	input  wire logic       aux_ovf,
	input  wire logic       ext_in,
	ccu_tmr_if.tmr          t
);
	logic [15:0] value_q;
	logic [15:0] reload_q;
	logic        step_q;
	logic        ovf_q;
	logic        ext_prev_q;
	logic        tick;

	always_comb
	begin
		unique case (t.src)
			ccu_pkg::SRC_PRESC: tick = ccu_pkg::presc_tick(presc, t.sel);
			ccu_pkg::SRC_AUX:   tick = aux_ovf;
			ccu_pkg::SRC_EXT:   tick = HAS_EXT && ext_in && !ext_prev_q;
			default:            tick = 1'b0;
		endcase
		tick = tick && t.run;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			ext_prev_q <= 1'b0;
		else if (ce)
			ext_prev_q <= ext_in;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			value_q <= ccu_pkg::TVAL_RST;
		else if (ce)
		begin
			if (t.wr_val)
				value_q <= t.wdata;
			else if (tick)
				value_q <= (value_q == ccu_pkg::TMR_MAX) ? reload_q : value_q + 16'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			reload_q <= ccu_pkg::TRLD_RST;
		else if (ce && t.wr_rld)
			reload_q <= t.wdata;
	end

	// A software write to the count wins over a tick, so no step or overflow is reported then.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			step_q <= 1'b0;
			ovf_q  <= 1'b0;
		end
		else if (ce)
		begin
			step_q <= tick && !t.wr_val;
			ovf_q  <= tick && !t.wr_val && value_q == ccu_pkg::TMR_MAX;
		end
	end

	assign t.value  = value_q;
	assign t.reload = reload_q;
	assign t.step   = step_q;
	assign t.ovf    = ovf_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_reload_on_ovf: assert property ($past(ce) && ovf_q && !$past(t.wr_rld) |-> value_q == $past(reload_q))
		else $error("timer did not restart from its reload value");
	chk_count_up: assert property ($past(ce) && step_q && !ovf_q |-> value_q == $past(value_q) + 16'h0001)
		else $error("timer did not advance by one");
	chk_ext_count: assert property (ce && HAS_EXT && t.run && t.src == ccu_pkg::SRC_EXT && ext_in && !ext_prev_q
		&& !t.wr_val |=> step_q)
		else $error("external count edge was not counted");
endmodule // ccu_timer

// ===== rtl/ccu_channel.sv
`timescale 1ns/1ps
module ccu_channel (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              ce,
	input  ccu_pkg::cc_mode_t      mode,
	input  wire logic              tsel,
	input  wire logic [15:0]       tv0,
	input  wire logic [15:0]       tv1,
	input  wire logic [1:0]        step,
	input  wire logic [1:0]        ovf,
	input  wire logic              pin_in,
	input  wire logic              wr,
	input  wire logic [15:0]       wdata,
	output logic [15:0]            value,
	output logic                   irq_set,
	output logic                   pin_set,
	output logic                   pin_clr,
	output logic                   pin_tgl,
	output logic                   dbl_tgl
);
	logic [15:0] cc_q;
	logic        prev_q;
	logic        once_q;
	logic [1:0]  hits_q;
	logic [15:0] tv;
	logic        ov;
	logic        cap;
	logic        match;
	logic        hit;
	logic        is_cmp;
	logic        once_mode;

	assign tv        = tsel ? tv1 : tv0;
	assign ov        = ovf[tsel];
	assign is_cmp    = mode inside {ccu_pkg::CM_CMP0, ccu_pkg::CM_CMP1, ccu_pkg::CM_CMP2, ccu_pkg::CM_CMP3,
		ccu_pkg::CM_DOUBLE};
	assign once_mode = mode inside {ccu_pkg::CM_CMP2, ccu_pkg::CM_CMP3};
	// Matching only on a timer step keeps a slow timer from firing every clock while it sits on the value.
	assign match     = is_cmp && step[tsel] && tv == cc_q;
	assign hit       = match && (!once_mode || !once_q || ov);
	assign cap       = (mode == ccu_pkg::CM_CAP_RISE && pin_in && !prev_q)
		|| (mode == ccu_pkg::CM_CAP_FALL && !pin_in && prev_q)
		|| (mode == ccu_pkg::CM_CAP_BOTH && pin_in != prev_q);
	assign irq_set   = cap || hit;
	assign pin_tgl   = match && mode == ccu_pkg::CM_CMP1;
	assign pin_set   = hit && mode == ccu_pkg::CM_CMP3;
	assign pin_clr   = ov && mode == ccu_pkg::CM_CMP3;
	assign dbl_tgl   = match && mode == ccu_pkg::CM_DOUBLE;
	assign value     = cc_q;

	always_ff @(posedge clk)
	begin
		if (srst)
			prev_q <= 1'b0;
		else if (ce)
			prev_q <= pin_in;
	end

	// A capture wins over a software write in the same cycle.
	always_ff @(posedge clk)
	begin
		if (srst)
			cc_q <= ccu_pkg::TVAL_RST;
		else if (ce)
		begin
			if (cap)
				cc_q <= tv;
			else if (wr)
				cc_q <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			once_q <= 1'b0;
		else if (ce)
		begin
			if (hit && once_mode)
				once_q <= 1'b1;
			else if (ov)
				once_q <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			hits_q <= 2'h0;
		else if (ce)
		begin
			if (ov || mode != ccu_pkg::CM_CMP2)
				hits_q <= {1'b0, irq_set && mode == ccu_pkg::CM_CMP2};
			else if (irq_set && hits_q != 2'h3)
				hits_q <= hits_q + 2'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_capture;
		ce && cap;
	endsequence

	chk_capture_load: assert property (s_capture |-> irq_set ##1 value == $past(tv))
		else $error("capture did not latch the timer");
	chk_cmp0_irq: assert property (mode == ccu_pkg::CM_CMP0 && match |-> irq_set && !pin_tgl && !pin_set)
		else $error("mode 0 match misbehaved");
	chk_cmp2_once: assert property (hits_q <= 2'h1)
		else $error("more than one mode 2 interrupt in a period");
endmodule // ccu_channel

// ===== dv/ccu_far_model.sv
`timescale 1ns/1ps
module ccu_far_model (
	input  wire logic        clk,
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe,
	output logic      [31:0] pin_in,
	output logic      [1:0]  ext_cnt,
	output logic             aux_ovf
);
	logic [31:0] drive_q;
	int          gap;

	// A driven pin reads back the block's own level; an undriven one sees the outside world.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_q);

	initial
	begin
		drive_q = 32'h0000_0000;
		ext_cnt = 2'h0;
		aux_ovf = 1'b0;
		gap     = 0;
	end

	task automatic set_pin(input int k, input logic lvl);
		drive_q[k] <= lvl;
		repeat (6) @(posedge clk);
	endtask

	// Source 0 and 1 are the external count pins, 2 the aux overflow; spacing varies to mix fast and slow events.
	task automatic pulses(input int src, input int n);
		repeat (n)
		begin
			gap = (gap + 1) % 3;
			if (src == 2)
				aux_ovf <= 1'b1;
			else
				ext_cnt[src] <= 1'b1;
			@(posedge clk);
			aux_ovf <= 1'b0;
			ext_cnt <= 2'h0;
			@(posedge clk);
			repeat (gap) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask
endmodule // ccu_far_model

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [11:0] VB = ccu_pkg::CCVAL_BASE;
	localparam logic [11:0] MB = ccu_pkg::CCMODE_BASE;
	localparam logic [11:0] TV = ccu_pkg::TVAL_OFS;
	localparam logic [11:0] TC = ccu_pkg::TCTRL_OFS;

	logic        SYS_CLK;
	logic        SRST;
	logic        CE;
	logic [11:0] AVS_ADDRESS;
	logic        AVS_READ;
	logic        AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic [31:0] CC_PIN_IN;
	logic [31:0] CC_PIN_OUT;
	logic [31:0] CC_PIN_OE;
	logic [1:0]  EXT_COUNT_IN;
	logic        AUX_OVF_IN;
	logic        IRQ;
	int          errors;
	int          num_checks;
	int          seed;
	int          mt;
	int          n;
	int          k;
	int          v;
	logic [31:0] rd;
	logic [31:0] cap;

	dual_capture_compare_array u_dut (
		.SYS_CLK         (SYS_CLK),
		.SRST            (SRST),
		.CE              (CE),
		.AVS_ADDRESS     (AVS_ADDRESS),
		.AVS_READ        (AVS_READ),
		.AVS_WRITE       (AVS_WRITE),
		.AVS_WRITEDATA   (AVS_WRITEDATA),
		.AVS_READDATA    (AVS_READDATA),
		.AVS_WAITREQUEST (AVS_WAITREQUEST),
		.CC_PIN_IN       (CC_PIN_IN),
		.CC_PIN_OUT      (CC_PIN_OUT),
		.CC_PIN_OE       (CC_PIN_OE),
		.EXT_COUNT_IN    (EXT_COUNT_IN),
		.AUX_OVF_IN      (AUX_OVF_IN),
		.IRQ             (IRQ)
	);

	ccu_far_model u_far (
		.clk     (SYS_CLK),
		.pin_out (CC_PIN_OUT),
		.pin_oe  (CC_PIN_OE),
		.pin_in  (CC_PIN_IN),
		.ext_cnt (EXT_COUNT_IN),
		.aux_ovf (AUX_OVF_IN)
	);

	initial
	begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// The request is held until waitrequest is seen low at an edge; read data is taken at that same edge.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int w;
		w = 0;
		AVS_ADDRESS   <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE     <= wr;
		AVS_READ      <= ~wr;
		do
		begin
			@(posedge SYS_CLK);
			w++;
		end
		while (AVS_WAITREQUEST !== 1'b0 && w < 50);
		if (w >= 50)
		begin
			errors++;
			$display("BAD %0t bus timeout", $time);
		end
		rd = AVS_READDATA;
		AVS_READ  <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge SYS_CLK);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp, what);
	endtask

	function automatic logic [11:0] ta(input int t, input logic [11:0] o);
		return 12'(ccu_pkg::TMR_BASE + 12'(16 * t) + o);
	endfunction

	function automatic logic [11:0] ca(input logic [11:0] base, input int c);
		return 12'(base + 12'(4 * c));
	endfunction

	initial
	begin
		repeat (20000) @(posedge SYS_CLK);
		errors++;
		$display("BAD %0t watchdog expired", $time);
		final_report();
	end

	initial
	begin
		seed          = 99191;
		errors        = 0;
		num_checks    = 0;
		SRST          = 1'b1;
		CE            = 1'b1;
		AVS_ADDRESS   = 12'h000;
		AVS_READ      = 1'b0;
		AVS_WRITE     = 1'b0;
		AVS_WRITEDATA = 32'h0000_0000;
		repeat (3) @(posedge SYS_CLK);
		SRST <= 1'b0;
		@(posedge SYS_CLK);
		chk(32'(IRQ), 32'h0, "irq reset");
		rchk(ccu_pkg::STATUS_OFS, 32'h0, "status reset");
		rchk(ta(3, ccu_pkg::TRLD_OFS), 32'h0, "reload reset");
		rchk(ca(MB, 31), 32'h0, "mode reset");
		rchk(12'h0f0, 32'h0, "unmapped read");
		$display("test reset done");
		for (int u = 0; u < 2; u++)
		begin
			k = 16 * u + 3;
			bus(1'b1, ta(2 * u, ccu_pkg::TRLD_OFS), 32'h0000_fff0);
			bus(1'b1, ta(2 * u, TV), 32'h0000_fffd);
			bus(1'b1, ta(2 * u, TC), 32'h0000_0030);
			n = 3 + $unsigned($random(seed)) % 4;
			u_far.pulses(u, n);
			mt = 'hfffd + n;
			if (mt > 'hffff)
				mt = mt - 'h10;
			rchk(ta(2 * u, TV), 32'(mt), "count and reload");
			v = mt + 2;
			bus(1'b1, ca(VB, k), 32'(v));
			bus(1'b1, ca(MB, k), 32'h0000_0005);
			u_far.pulses(u, 2);
			chk(32'({CC_PIN_OE[k], CC_PIN_OUT[k]}), 32'h3, "toggle first");
			bus(1'b1, ta(2 * u, TV), 32'(v - 1));
			u_far.pulses(u, 1);
			chk(32'({CC_PIN_OE[k], CC_PIN_OUT[k]}), 32'h2, "toggle second");
			bus(1'b1, ca(VB, k + 1), 32'(v + 1));
			bus(1'b1, ca(MB, k + 1), 32'h0000_0007);
			u_far.pulses(u, 1);
			chk(32'(CC_PIN_OUT[k + 1]), 32'h1, "set on match");
			u_far.pulses(u, 'hffff - v);
			chk(32'(CC_PIN_OUT[k + 1]), 32'h0, "clear on overflow");
			bus(1'b0, ccu_pkg::STATUS_OFS, 32'h0);
			chk(rd & (32'h3 << k), 32'h3 << k, "compare flags");
			rchk(ta(2 * u, TV), 32'h0000_fff0, "overflow reload");
		end
		$display("test timers and compare done");
		bus(1'b1, ca(VB, 5), 32'h0000_fff2);
		bus(1'b1, ca(VB, 6), 32'h0000_fff2);
		bus(1'b1, ca(MB, 5), 32'h0000_0004);
		bus(1'b1, ca(MB, 6), 32'h0000_0006);
		bus(1'b1, ccu_pkg::CLEAR_OFS, 32'hffff_ffff);
		u_far.pulses(0, 2);
		bus(1'b0, ccu_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h60, 32'h60, "first match");
		chk(32'(CC_PIN_OE[6:5]), 32'h0, "pin left alone");
		bus(1'b1, ccu_pkg::CLEAR_OFS, 32'h0000_0060);
		bus(1'b1, ta(0, TV), 32'h0000_fff1);
		u_far.pulses(0, 1);
		bus(1'b0, ccu_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h60, 32'h20, "once per period");
		bus(1'b1, ccu_pkg::ENABLE_OFS, 32'h0000_0020);
		@(posedge SYS_CLK);
		chk(32'(IRQ), 32'h1, "irq raised");
		rchk(ccu_pkg::ENABLE_OFS, 32'h0000_0020, "enable readback");
		bus(1'b1, ccu_pkg::ENABLE_OFS, 32'h0);
		@(posedge SYS_CLK);
		chk(32'(IRQ), 32'h0, "irq masked");
		bus(1'b0, ccu_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h20, 32'h20, "flag sticky");
		bus(1'b1, ccu_pkg::CLEAR_OFS, 32'h0000_0020);
		bus(1'b0, ccu_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h20, 32'h0, "flag cleared");
		$display("test modes and irq done");
		for (int m = 1; m < 4; m++)
		begin
			bus(1'b1, ca(MB, 8), 32'(m));
			bus(1'b1, ca(VB, 8), 32'h0);
			bus(1'b1, ccu_pkg::CLEAR_OFS, 32'hffff_ffff);
			v = $unsigned($random(seed)) % 'h10000;
			bus(1'b1, ta(0, TV), 32'(v));
			u_far.set_pin(8, 1'b1);
			cap = (m != 2) ? 32'(v) : 32'h0;
			rchk(ca(VB, 8), cap, "capture rise");
			bus(1'b1, ta(0, TV), 32'(v ^ 'h00ff));
			u_far.set_pin(8, 1'b0);
			if (m != 1)
				cap = 32'(v ^ 'h00ff);
			rchk(ca(VB, 8), cap, "capture fall");
			bus(1'b0, ccu_pkg::STATUS_OFS, 32'h0);
			chk(rd & 32'h100, 32'h100, "capture flag");
		end
		bus(1'b1, ta(1, TV), 32'h0);
		bus(1'b1, ta(1, TC), 32'h0000_0028);
		n = 2 + $unsigned($random(seed)) % 5;
		u_far.pulses(2, n);
		rchk(ta(1, TV), 32'(n), "aux count");
		bus(1'b1, ca(MB, 9), 32'h0000_0011);
		u_far.set_pin(9, 1'b1);
		rchk(ca(VB, 9), 32'(n), "second timer capture");
		$display("test capture done");
		bus(1'b1, ta(0, TV), 32'h0000_0100);
		bus(1'b1, ca(VB, 2), 32'h0000_0102);
		bus(1'b1, ca(VB, 10), 32'h0000_0104);
		bus(1'b1, ca(MB, 2), 32'h0000_0008);
		bus(1'b1, ca(MB, 10), 32'h0000_0008);
		u_far.pulses(0, 2);
		chk(32'({CC_PIN_OE[2], CC_PIN_OUT[2]}), 32'h3, "double first");
		u_far.pulses(0, 2);
		chk(32'({CC_PIN_OE[2], CC_PIN_OUT[2]}), 32'h2, "double second");
		$display("test double done");
		// The prescaler runs free, so a window of five periods may hold one extra tick.
		for (int s = 0; s < 3; s++)
		begin
			bus(1'b1, ta(1, TV), 32'h0);
			bus(1'b1, ta(1, TC), 32'(32 + s));
			repeat (5 * (8 << s)) @(posedge SYS_CLK);
			bus(1'b1, ta(1, TC), 32'(s));
			bus(1'b0, ta(1, TV), 32'h0);
			chk(32'(rd inside {32'd5, 32'd6}), 32'h1, "prescale ticks");
		end
		$display("test prescaler done");
		final_report();
	end
endmodule // tb_top
